// ===== pll_synth_pkg.sv
// constants shared by the synthesizer core, its checker and its bench
// assumes a single 100 MHz system clock and a plain register port
package pll_synth_pkg;

   // clock period of sys_clk in ns
   localparam int CLK_PERIOD_NS = 10;

   // width of the divide-by-n preset inputs
   localparam int N_BITS = 14;
   // narrowest preset that still holds the offset value
   localparam int N_BITS_MIN = 10;
   // fixed offset added while the transmit/receive select is low
   localparam int N_OFFSET = 856;
   // supported preset range, kept by whoever sets the switches
   localparam int N_MIN = 3;
   localparam int N_MAX = 16383;

   // reference divider: code width, counter width and ratio table
   localparam int REF_SEL_BITS = 3;
   localparam int REF_BITS = 14;
   localparam logic [REF_BITS-1:0] REF_DIV_TABLE [0:7] = '{
      14'h0008, 14'h0080, 14'h0100, 14'h0200,
      14'h0400, 14'h0800, 14'h096A, 14'h2000};

   // least width of the coincidence pulse on both detector outputs
   localparam int PD_MIN_PULSE_NS = 20;
   localparam int PD_MIN_CYC = (PD_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PD_CNT_BITS = 4;

   // phase detector states, gray coded in declaration order only
   typedef enum logic [1:0] {
      PD_IDLE = 2'h0,
      PD_REF_LEAD = 2'h1,
      PD_BOTH = 2'h3,
      PD_VCO_LEAD = 2'h2
   } pd_state_t;

   // register port
   localparam int ADDR_BITS = 4;
   localparam logic [ADDR_BITS-1:0] ADDR_STATUS = 4'h0;
   localparam logic [ADDR_BITS-1:0] ADDR_ENABLE = 4'h4;
   localparam logic [ADDR_BITS-1:0] ADDR_CLEAR = 4'h8;
   localparam logic [ADDR_BITS-1:0] ADDR_LIVE = 4'hC;

   // event bits of status, enable and clear
   localparam int EV_BITS = 4;
   localparam int EV_LOCK_LOST = 0;
   localparam int EV_LOCK_GAINED = 1;
   localparam int EV_REF_CYCLE = 2;
   localparam int EV_VCO_CYCLE = 3;
   localparam logic [EV_BITS-1:0] EV_RESET = 4'h0;

   // fields of the live view register
   localparam int LIVE_LOCK = 0;
   localparam int LIVE_REF_LEAD = 1;
   localparam int LIVE_VCO_LEAD = 2;
   localparam int LIVE_TX_RX = 3;
   localparam int LIVE_RANGE_BAD = 4;
   localparam int LIVE_TOTAL_LSB = 16;

endpackage

// ===== pin_sync.sv
// three-stage synchroniser for a group of asynchronous pins
// assumes the pins change far slower than sys_clk
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out
);

   // all state: three stages and the accepted value
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } sync_t;

   sync_t st_reg;
   sync_t st_next;

   // refuse an empty group
   if (WIDTH < 1) begin : g_width_check
      $error("pin_sync needs WIDTH of at least one");
   end

   // shift the stages; a bit is taken once stages two and three agree
   always_comb begin
      st_next = st_reg;
      st_next.s1 = pin_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int i = 0; i < WIDTH; i++) begin
         // stage one feeds only stage two
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.q[i] = st_reg.s3[i];
         end
      end
   end

   // synchronous reset clears every stage
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pin_out = st_reg.q;

endmodule

// ===== pll_synth_core.sv
// digital core of a parallel-programmed single-modulus pll synthesizer
// assumes pins are asynchronous and far slower than the 100 MHz sys_clk
// and that srst alone starts it in a known state, the pins offer no reset
// software sees events, enables and a live view through a small register port
//
// What this block does
// R1 - reference divider ratio from three-bit code
// R2 - n counter counts down, reloads on the edge that finds it at one
// R3 - n preset fourteen bits, bit zero lsb
// R4 - programmer keeps n within three to 16383
// R5 - offset 856 added while select low
// R6 - single-ended output: low fast, high slow
// R7 - double-ended outputs: leading side pulses low
// R8 - coincidence gives brief low on both
// R9 - divided vco copy on its own pin
// R10 - lock high when matched, pulses low otherwise
// R11 - n counter clocked by the frequency input
// R12 - error width equals edge time difference
// R13 - one reference edge per division cycle
`timescale 1ns/1ps
module pll_synth_core
   import pll_synth_pkg::*;
#(
   // width of the n preset pins
   parameter int N_WIDTH = N_BITS,
   // coincidence pulse length in sys_clk cycles
   parameter int PD_MIN_CYCLES = PD_MIN_CYC
) (
   // system clock and synchronous reset
   input wire logic sys_clk,
   input wire logic srst,
   // reference oscillator and vco pins
   input wire logic crystal_input,
   output logic crystal_drive,
   input wire logic freq_input,
   // program pins, static while the loop runs
   input wire logic [REF_SEL_BITS-1:0] ref_divide_select,
   input wire logic [N_WIDTH-1:0] divide_preset_value,
   input wire logic tx_rx_select,
   // phase detector, divided vco and lock outputs
   output logic tristate_phase_error,
   output logic tristate_phase_error_oe,
   output logic ref_error_n,
   output logic vco_error_n,
   output logic divided_vco_output,
   output logic lock_indicator,
   // register port and interrupt
   input wire logic [ADDR_BITS-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic irq
);

   // n counter is one bit wider so preset plus offset never wraps
   localparam int CW = N_WIDTH + 1;
   // width of the synchronised pin group
   localparam int SW = 2 + REF_SEL_BITS + N_WIDTH + 1;

   // refuse widths the counters and the offset cannot serve
   if (N_WIDTH < N_BITS_MIN || N_WIDTH > 16) begin : g_nw_check
      $error("N_WIDTH must lie between 10 and 16");
   end
   // refuse a coincidence pulse the counter cannot hold
   if (PD_MIN_CYCLES < 1 || PD_MIN_CYCLES >= (1 << PD_CNT_BITS)) begin : g_pd_check
      $error("PD_MIN_CYCLES must lie between 1 and 15");
   end

   // all state of the core
   typedef struct packed {
      logic xtal_prev;                 // last crystal level
      logic fin_prev;                  // last frequency input level
      logic [REF_BITS-1:0] ref_cnt;    // reference divider count
      logic [CW-1:0] vco_cnt;          // n counter count
      logic vco_out;                   // divided vco pin level
      pd_state_t pd_state;             // phase detector state
      logic [PD_CNT_BITS-1:0] pd_cnt;  // coincidence pulse timer
      logic ref_err_n;                 // reference side output
      logic vco_err_n;                 // vco side output
      logic pd_drive;                  // three-state output level
      logic pd_oe;                     // three-state output enable
      logic lock;                      // lock indicator level
      logic xtal_drive;                // oscillator feedback level
      logic [EV_BITS-1:0] status;      // sticky events
      logic [EV_BITS-1:0] enable;      // interrupt enables
      logic [31:0] rdata;              // read data, one cycle late
   } core_t;

   core_t st_reg;
   core_t st_next;

   // synchronised pin group
   logic [SW-1:0] sync_q;
   logic xtal_s;
   logic fin_s;
   logic [REF_SEL_BITS-1:0] sel_s;
   logic [N_WIDTH-1:0] preset_s;
   logic txrx_s;

   // all pins pass the three-stage synchroniser together
   pin_sync #(
      .WIDTH(SW)
   ) u_pin_sync (
      .sys_clk(sys_clk),
      .srst(srst),
      .pin_in({tx_rx_select, divide_preset_value, ref_divide_select, freq_input, crystal_input}),
      .pin_out(sync_q)
   );

   // split the group back into its fields
   assign xtal_s = sync_q[0];
   assign fin_s = sync_q[1];
   assign sel_s = sync_q[2 +: REF_SEL_BITS];
   assign preset_s = sync_q[2 + REF_SEL_BITS +: N_WIDTH];
   assign txrx_s = sync_q[SW-1];

   // edge strobes and the dividers' active edges
   logic xtal_rise;
   logic fin_rise;
   logic ref_tick;
   logic vco_tick;
   logic [REF_BITS-1:0] ref_ratio;
   logic [CW-1:0] n_total;
   logic range_bad;

   // one-cycle strobes on rising input edges
   always_comb begin
      xtal_rise = xtal_s & ~st_reg.xtal_prev;
      fin_rise = fin_s & ~st_reg.fin_prev;
   end

   // R1 ratio lookup
   assign ref_ratio = REF_DIV_TABLE[sel_s];

   // R5 offset adder
   // R3 preset bit zero is the lsb
   always_comb begin
      if (txrx_s) begin
         // select high: preset used as it stands
         n_total = {1'b0, preset_s};
      end else begin
         // select low: fixed offset added, extra bit keeps the carry
         n_total = {1'b0, preset_s} + CW'(N_OFFSET);
      end
   end

   // R4 range flag for software, the divider itself is not protected
   assign range_bad = (preset_s < N_WIDTH'(N_MIN)) || (32'(preset_s) > N_MAX);

   // R13 one active edge per division cycle
   assign ref_tick = xtal_rise && (st_reg.ref_cnt <= REF_BITS'(1));
   // R11 n counter stepped by frequency input edges
   assign vco_tick = fin_rise && (st_reg.vco_cnt <= CW'(1));

   // next state of the whole core
   always_comb begin
      // every field holds unless a branch below moves it
      st_next = st_reg;
      st_next.xtal_prev = xtal_s;
      st_next.fin_prev = fin_s;
      // inverter feedback for an external crystal
      st_next.xtal_drive = ~xtal_s;

      // reference divider
      if (xtal_rise) begin
         // R1 reload with the selected ratio
         if (ref_tick) begin
            st_next.ref_cnt = ref_ratio;
         end else begin
            // one reference edge consumed
            st_next.ref_cnt = st_reg.ref_cnt - REF_BITS'(1);
         end
      end

      // n counter and its pin copy
      if (fin_rise) begin
         // R2 count down, reload on the edge that finds the count at one or zero
         if (vco_tick) begin
            st_next.vco_cnt = n_total;
         end else begin
            // one frequency input edge consumed
            st_next.vco_cnt = st_reg.vco_cnt - CW'(1);
         end
         // R9 pin high for the input period after reload
         st_next.vco_out = vco_tick;
      end

      // phase detector
      case (st_reg.pd_state)
         PD_IDLE: begin
            // waiting for the first divided edge of a cycle
            if (ref_tick && vco_tick) begin
               // R8 edges together, brief pulse on both
               st_next.pd_state = PD_BOTH;
               st_next.pd_cnt = PD_CNT_BITS'(PD_MIN_CYCLES - 1);
            end else if (ref_tick) begin
               // reference first: the vco lags
               st_next.pd_state = PD_REF_LEAD;
            end else if (vco_tick) begin
               // vco first: it leads
               st_next.pd_state = PD_VCO_LEAD;
            end
         end
         PD_REF_LEAD: begin
            // R12 error lasts until the vco edge
            // a further reference edge is absorbed here
            if (vco_tick) begin
               st_next.pd_state = PD_BOTH;
               st_next.pd_cnt = PD_CNT_BITS'(PD_MIN_CYCLES - 1);
            end
         end
         PD_VCO_LEAD: begin
            // R12 error lasts until the reference edge
            // a further vco edge is absorbed here
            if (ref_tick) begin
               st_next.pd_state = PD_BOTH;
               st_next.pd_cnt = PD_CNT_BITS'(PD_MIN_CYCLES - 1);
            end
         end
         PD_BOTH: begin
            // hold both low for the minimum width
            if (st_reg.pd_cnt != '0) begin
               st_next.pd_cnt = st_reg.pd_cnt - PD_CNT_BITS'(1);
            end else if (ref_tick && !vco_tick) begin
               // lone reference edge on the last cycle starts a new error
               st_next.pd_state = PD_REF_LEAD;
            end else if (vco_tick && !ref_tick) begin
               // lone vco edge on the last cycle starts a new error
               st_next.pd_state = PD_VCO_LEAD;
            end else begin
               // pulse done, both outputs rise again
               st_next.pd_state = PD_IDLE;
            end
         end
         default: begin
            // unused code falls back to idle
            st_next.pd_state = PD_IDLE;
         end
      endcase

      // outputs decoded from the next state so they line up with it
      // R7 leading side pulses low
      st_next.ref_err_n = !(st_next.pd_state == PD_REF_LEAD || st_next.pd_state == PD_BOTH);
      st_next.vco_err_n = !(st_next.pd_state == PD_VCO_LEAD || st_next.pd_state == PD_BOTH);
      // R6 high when vco lags, low when it leads
      st_next.pd_drive = (st_next.pd_state == PD_REF_LEAD);
      // R6 released when phases coincide
      st_next.pd_oe = (st_next.pd_state == PD_REF_LEAD) || (st_next.pd_state == PD_VCO_LEAD);
      // R10 lock low while an error pulse runs
      st_next.lock = !st_next.pd_oe;

      // sticky events; a set in the clear cycle wins
      // software clears the bits written as one
      if (reg_write && reg_addr == ADDR_CLEAR) begin
         st_next.status = st_reg.status & ~reg_wdata[EV_BITS-1:0];
      end
      // lock indicator falls
      if (st_reg.lock && !st_next.lock) begin
         st_next.status[EV_LOCK_LOST] = 1'b1;
      end
      // lock indicator rises
      if (!st_reg.lock && st_next.lock) begin
         st_next.status[EV_LOCK_GAINED] = 1'b1;
      end
      // reference divider completed a cycle
      if (ref_tick) begin
         st_next.status[EV_REF_CYCLE] = 1'b1;
      end
      // n counter completed a cycle
      if (vco_tick) begin
         st_next.status[EV_VCO_CYCLE] = 1'b1;
      end

      // enable register write
      if (reg_write && reg_addr == ADDR_ENABLE) begin
         st_next.enable = reg_wdata[EV_BITS-1:0];
      end

      // read data stands only in the cycle after the strobe
      st_next.rdata = '0;
      if (reg_read) begin
         if (reg_addr == ADDR_STATUS) begin
            // sticky events
            st_next.rdata[EV_BITS-1:0] = st_reg.status;
         end else if (reg_addr == ADDR_ENABLE) begin
            // interrupt enables
            st_next.rdata[EV_BITS-1:0] = st_reg.enable;
         end else if (reg_addr == ADDR_LIVE) begin
            // live detector state and the reload value in use
            st_next.rdata[LIVE_LOCK] = st_reg.lock;
            st_next.rdata[LIVE_REF_LEAD] = (st_reg.pd_state == PD_REF_LEAD);
            st_next.rdata[LIVE_VCO_LEAD] = (st_reg.pd_state == PD_VCO_LEAD);
            st_next.rdata[LIVE_TX_RX] = txrx_s;
            st_next.rdata[LIVE_RANGE_BAD] = range_bad;
            st_next.rdata[LIVE_TOTAL_LSB +: CW] = n_total;
         end else begin
            // clear register and unmapped addresses read zero
            st_next.rdata = '0;
         end
      end
   end

   // state register; reset leaves both detector outputs high and lock high
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_reg <= '{
            xtal_prev: 1'b0,
            fin_prev: 1'b0,
            ref_cnt: '0,
            vco_cnt: '0,
            vco_out: 1'b0,
            pd_state: PD_IDLE,
            pd_cnt: '0,
            ref_err_n: 1'b1,
            vco_err_n: 1'b1,
            pd_drive: 1'b0,
            pd_oe: 1'b0,
            lock: 1'b1,
            xtal_drive: 1'b1,
            status: EV_RESET,
            enable: EV_RESET,
            rdata: '0
         };
      end else begin
         // running: take the whole next state
         st_reg <= st_next;
      end
   end

   // pin drivers straight from flip-flops
   assign crystal_drive = st_reg.xtal_drive;
   assign tristate_phase_error = st_reg.pd_drive;
   assign tristate_phase_error_oe = st_reg.pd_oe;
   assign ref_error_n = st_reg.ref_err_n;
   assign vco_error_n = st_reg.vco_err_n;
   // R9 buffered counter output
   assign divided_vco_output = st_reg.vco_out;
   assign lock_indicator = st_reg.lock;
   assign reg_rdata = st_reg.rdata;

   // level interrupt while any enabled event is pending
   assign irq = |(st_reg.status & st_reg.enable);

endmodule

// ===== pll_synth_core_assertions.sv
// port checks of the synthesizer core, bound onto every instance
// assumes one sys_clk domain with synchronous active-high srst
`timescale 1ns/1ps
module pll_synth_core_checker
   import pll_synth_pkg::*;
#(
   parameter int PD_MIN_CYCLES = PD_MIN_CYC
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic tristate_phase_error,
   input wire logic tristate_phase_error_oe,
   input wire logic ref_error_n,
   input wire logic vco_error_n,
   input wire logic divided_vco_output,
   input wire logic lock_indicator,
   input wire logic [ADDR_BITS-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   logic [EV_BITS-1:0] en_reg; // shadow of the enable register
   logic [3:0] both_cnt_reg; // length of the running coincidence pulse
   logic both_low; // both detector outputs low together
   assign both_low = !ref_error_n && !vco_error_n;
   // follow enable writes and time each coincidence pulse
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         en_reg <= EV_RESET;
         both_cnt_reg <= 4'h0;
      end else begin
         if (reg_write && reg_addr == ADDR_ENABLE) begin
            en_reg <= reg_wdata[EV_BITS-1:0];
         end
         both_cnt_reg <= both_low ? both_cnt_reg + 4'h1 : 4'h0;
      end
   end
   rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside a read");
   irq_masked_a: assert property (en_reg == EV_RESET |-> !irq)
      else $error("interrupt while all events masked");
   lead_lock_a: assert property (tristate_phase_error_oe == !lock_indicator)
      else $error("lock indicator disagrees with error drive");
   ref_lead_a: assert property (tristate_phase_error_oe && tristate_phase_error |-> !ref_error_n && vco_error_n)
      else $error("lagging vco not shown on reference side");
   vco_lead_a: assert property (tristate_phase_error_oe && !tristate_phase_error |-> ref_error_n && !vco_error_n)
      else $error("leading vco not shown on vco side");
   coincide_a: assert property (both_low |-> !tristate_phase_error_oe && lock_indicator)
      else $error("coincidence pulse drives the single-ended pin");
   coin_width_a: assert property ($fell(both_low) |-> both_cnt_reg == PD_MIN_CYCLES)
      else $error("coincidence pulse width wrong");
   vco_copy_a: assert property ($rose(divided_vco_output) |-> ##[1:40] !divided_vco_output)
      else $error("divided vco copy stuck high");
   cover property (both_low);
   cover property (tristate_phase_error_oe && tristate_phase_error);
   cover property (tristate_phase_error_oe && !tristate_phase_error);
endmodule
bind pll_synth_core pll_synth_core_checker #(.PD_MIN_CYCLES(PD_MIN_CYCLES)) i_pll_synth_core_checker (.sys_clk,
   .srst, .tristate_phase_error, .tristate_phase_error_oe, .ref_error_n, .vco_error_n, .divided_vco_output,
   .lock_indicator, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq);

// ===== pll_partner_model.sv
// behavioural crystal and vco sources for the synthesizer core
// assumes half periods of at least four sys_clk cycles
`timescale 1ns/1ps
module pll_partner_model (
   input wire logic sys_clk,
   input wire logic run,
   input wire logic [3:0] xtal_half,
   input wire logic [3:0] vco_half,
   output logic crystal_input,
   output logic freq_input
);
   logic [3:0] x_cnt; // crystal half period count
   logic [3:0] v_cnt; // vco half period count
   // both sources start low and in phase when run rises
   always @(posedge sys_clk) begin
      x_cnt <= (!run || x_cnt == xtal_half - 4'h1) ? 4'h0 : x_cnt + 4'h1;
      crystal_input <= run && (crystal_input ^ (x_cnt == xtal_half - 4'h1));
   end
   always @(posedge sys_clk) begin
      v_cnt <= (!run || v_cnt == vco_half - 4'h1) ? 4'h0 : v_cnt + 4'h1;
      freq_input <= run && (freq_input ^ (v_cnt == vco_half - 4'h1));
   end
endmodule

// ===== pll_synth_core_tb_top.sv
// self-checking bench for the synthesizer core with crystal and vco models
// assumes 100 MHz sys_clk and sources slow enough for the pin synchronisers
`timescale 1ns/1ps
module pll_synth_core_tb_top;
   import pll_synth_pkg::*;
   logic sys_clk = 1'b0; // system clock
   logic srst = 1'b1; // synchronous reset
   logic run = 1'b0; // starts both sources
   logic clr = 1'b1; // clears the seen flags
   logic crystal_input, crystal_drive, freq_input; // source pins
   logic [REF_SEL_BITS-1:0] ref_divide_select = 3'h0; // divider code
   logic [N_BITS-1:0] divide_preset_value = 14'h0008; // n preset
   logic tx_rx_select = 1'b1; // high adds no offset
   logic tristate_phase_error, tristate_phase_error_oe, ref_error_n, vco_error_n, divided_vco_output;
   logic lock_indicator, irq, reg_write = 1'b0, reg_read = 1'b0;
   logic [ADDR_BITS-1:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic ref_d, fv_d, seen_ref, seen_vco, seen_coin, seen_unlock, drv_bad; // edge history and flags
   logic [4:0] xh; // crystal history, as deep as the synchroniser plus feedback flop
   int cyc, n_ref, n_fv, t_ref, t_fv, n, n_mismatch = 0, cmp_count = 0;
   int codes[4] = '{0, 1, 2, 6}; // divider codes timed
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   pll_synth_core i_pll_synth_core (.sys_clk, .srst, .crystal_input, .crystal_drive, .freq_input,
      .ref_divide_select, .divide_preset_value, .tx_rx_select, .tristate_phase_error, .tristate_phase_error_oe,
      .ref_error_n, .vco_error_n, .divided_vco_output, .lock_indicator, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .irq);
   pll_partner_model i_pll_partner_model (.sys_clk, .run, .xtal_half(4'h4), .vco_half(4'h4), .crystal_input,
      .freq_input);
   // timestamp detector and divided vco edges, latch what the detector showed
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      ref_d <= ref_error_n;
      fv_d <= divided_vco_output;
      // stamp before count, so a waiter woken by the count reads the new stamp
      if (ref_d && !ref_error_n) begin
         t_ref <= cyc;
         n_ref <= n_ref + 1;
      end
      if (!fv_d && divided_vco_output) begin
         t_fv <= cyc;
         n_fv <= n_fv + 1;
      end
      seen_ref <= !clr && (seen_ref || (tristate_phase_error_oe && tristate_phase_error && !lock_indicator));
      seen_vco <= !clr && (seen_vco || (tristate_phase_error_oe && !tristate_phase_error && !lock_indicator));
      seen_coin <= !clr && (seen_coin || (!ref_error_n && !vco_error_n));
      seen_unlock <= !clr && (seen_unlock || !lock_indicator);
      // oscillator feedback must be the crystal level inverted, five edges late
      xh <= {xh[3:0], crystal_input};
      drv_bad <= !clr && (drv_bad || (crystal_drive == xh[4]));
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      @(negedge sys_clk);
      check(reg_rdata & mask, exp);
      @(posedge sys_clk);
   endtask
   task automatic irq_is(input logic exp);
      @(negedge sys_clk);
      check({31'h0, irq}, {31'h0, exp});
      @(posedge sys_clk);
   endtask
   // period between the third and second event after a settings change
   task automatic measure(input bit fv, input int exp);
      int c0;
      int p;
      c0 = fv ? n_fv : n_ref;
      wait ((fv ? n_fv : n_ref) == c0 + 2);
      p = fv ? t_fv : t_ref;
      wait ((fv ? n_fv : n_ref) == c0 + 3);
      check((fv ? t_fv : t_ref) - p, exp);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #990000;
      n_mismatch++;
      conclude();
   end
   initial begin
      void'($urandom(21646));
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      rd(ADDR_CLEAR, 32'hFFFFFFFF, 32'h0);
      d = $urandom;
      wr(4'h1, d);
      rd(4'h1, 32'hFFFFFFFF, 32'h0);
      wr(ADDR_ENABLE, d);
      rd(ADDR_ENABLE, 32'hFFFFFFFF, {28'h0, d[3:0]});
      // sources still stopped, so a wide preset cannot be loaded into the counter
      n = $urandom_range(16383, 3);
      divide_preset_value <= 14'(n);
      repeat (5) @(posedge sys_clk);
      rd(ADDR_LIVE, 32'h7FFF001F, (32'(n) << 16) | 32'h9);
      divide_preset_value <= 14'h0008;
      wr(ADDR_ENABLE, 32'h1);
      run <= 1'b1;
      clr <= 1'b0;
      repeat (400) @(posedge sys_clk);
      check(seen_coin, 1'b1);
      check(seen_unlock, 1'b0);
      irq_is(1'b0);
      divide_preset_value <= 14'h0009;
      repeat (200) @(posedge sys_clk);
      divide_preset_value <= 14'h0008;
      repeat (200) @(posedge sys_clk);
      check(seen_ref, 1'b1);
      irq_is(1'b1);
      rd(ADDR_STATUS, 32'h1, 32'h1);
      wr(ADDR_ENABLE, 32'h0);
      irq_is(1'b0);
      wr(ADDR_ENABLE, 32'h1);
      @(negedge ref_error_n);
      repeat (5) @(posedge sys_clk);
      wr(ADDR_CLEAR, 32'h1);
      irq_is(1'b0);
      repeat (80) @(posedge sys_clk);
      irq_is(1'b1);
      divide_preset_value <= 14'h0007;
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      repeat (400) @(posedge sys_clk);
      check(seen_vco, 1'b1);
      divide_preset_value <= 14'h0003;
      measure(1'b1, 24);
      foreach (codes[i]) begin
         ref_divide_select <= 3'(codes[i]);
         measure(1'b0, 8 * REF_DIV_TABLE[codes[i]]);
      end
      n = $urandom_range(500, 3);
      divide_preset_value <= 14'(n);
      measure(1'b1, 8 * n);
      n = $urandom_range(40, 3);
      divide_preset_value <= 14'(n);
      tx_rx_select <= 1'b0;
      measure(1'b1, 8 * (n + 856));
      check(drv_bad, 1'b0);
      conclude();
   end
endmodule
